/* src/nfc_pkg.sv */
/* Shared constants of the parallel NOR flash host controller.
   Assumes a 20 MHz pclk; pin timing figures are defaults to be tuned. */
`default_nettype none
package nfc_pkg;
    // Geometry
    localparam int ADDR_W = 25;
    localparam int DATA_W = 16;
    localparam int BLOCK_LSB = 17;
    localparam int BLOCK_W = 8;
    localparam int NUM_BLOCKS = 256;
    localparam int PROT_REG_BITS = 128;
    localparam logic [ADDR_W-1:0] ID_WORD_ADDR = 25'h000_0001;
    // Arbitrary value, not a real part code
    localparam logic [DATA_W-1:0] DEVICE_CODE = 16'h5A5A;
    ////////////////////////////////////////////////////////////////////////////
    // Timing, least values in ns
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_WE_LOW_NS = 100;
    localparam int T_ACCESS_NS = 150;
    localparam int T_RP_LOW_NS = 200;
    localparam int T_RESET_TO_OUTPUT_VALID_NS = 1000;
    localparam int T_RESET_TO_WRITE_NS = 2000;
    localparam int T_STS_SETTLE_NS = 500;
    localparam logic [7:0] WE_LOW_CYC = 8'((T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] ACCESS_CYC = 8'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RP_LOW_CYC = 8'((T_RP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] OVALID_CYC =
        8'((T_RESET_TO_OUTPUT_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WAKE_CYC = 8'((T_RESET_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] SETTLE_CYC = 8'((T_STS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RP_LOW_LOAD = RP_LOW_CYC - 8'h01;
    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_WDATA = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [7:0] REG_CFG = 8'h14;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_WRITE_WAIT = 2'h2;
    localparam logic [1:0] OP_RESET = 2'h3;
    localparam int CFG_WIDE_BIT = 0;
    localparam int CFG_CE_ACT_LSB = 1;
    localparam int CFG_CE_IDLE_LSB = 4;
    localparam logic CFG_WIDE_RST = 1'b1;
    localparam logic [2:0] CE_ACT_RST = 3'h0;
    localparam logic [2:0] CE_IDLE_RST = 3'h7;
    localparam int ST_RISE = 2;
    localparam int ST_ERR = 3;
    localparam int ST_DONE = 4;
endpackage : nfc_pkg
`default_nettype wire

/* src/nfc_cyc_if.sv */
/* Request/answer bundle between the sequencer and the pin cycle engine.
   Assumes both ends run on the same pclk. */
`default_nettype none
interface nfc_cyc_if;
    import nfc_pkg::*;
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic [2:0] ce_act;
    logic [2:0] ce_idle;
    modport ctl(output req, wr, addr, wdata, ce_act, ce_idle, input rdata, done);
    modport eng(input req, wr, addr, wdata, ce_act, ce_idle, output rdata, done);
endinterface : nfc_cyc_if
`default_nettype wire

/* src/nfc_timer.sv */
/* Down counter that flags expiry of a loaded cycle count.
   Assumes load pulses come from the sequencer on pclk. */
`default_nettype none
module nfc_timer
    import nfc_pkg::*;
#(
    parameter logic [7:0] INIT = 8'h00
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [7:0] load_val,
    output logic expired
);
    logic [7:0] count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= INIT;
        end else if (load) begin
            count <= load_val;
        end else if (count != 8'h00) begin
            count <= count - 8'h01;
        end
    end

    assign expired = (count == 8'h00);
endmodule : nfc_timer
`default_nettype wire

/* src/nfc_cycle.sv */
/* Pin cycle engine: one read or write bus cycle on the flash pins.
   Assumes req is a one-cycle pulse taken only while idle. */
`default_nettype none
module nfc_cycle
    import nfc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    nfc_cyc_if.eng cyc,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [2:0] chip_select_lines,
    output logic oe_n,
    output logic we_n
);
    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} nfc_cyc_e;
    nfc_cyc_e st;
    logic [7:0] cnt;
    logic is_wr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= C_IDLE;
            cnt <= 8'h00;
            is_wr <= 1'b0;
            flash_addr <= '0;
            dq_out <= '0;
            dq_oe_n <= 1'b1;
            chip_select_lines <= CE_IDLE_RST;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            cyc.done <= 1'b0;
        end else begin
            cyc.done <= 1'b0;
            unique case (st)
                C_IDLE: begin
                    chip_select_lines <= cyc.ce_idle;
                    if (cyc.req) begin
                        flash_addr <= cyc.addr;
                        dq_out <= cyc.wdata;
                        dq_oe_n <= !cyc.wr;
                        is_wr <= cyc.wr;
                        chip_select_lines <= cyc.ce_act;
                        st <= C_SETUP;
                    end
                end
                C_SETUP: begin
                    if (is_wr) begin
                        we_n <= 1'b0;
                        cnt <= WE_LOW_CYC - 8'h01;
                    end else begin
                        oe_n <= 1'b0;
                        cnt <= ACCESS_CYC - 8'h01;
                    end
                    st <= C_STROBE;
                end
                C_STROBE: begin
                    if (cnt == 8'h00) begin
                        we_n <= 1'b1;
                        oe_n <= 1'b1;
                        st <= C_HOLD;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                C_HOLD: begin
                    // Address and data held a full cycle past the strobe edge
                    dq_oe_n <= 1'b1;
                    chip_select_lines <= cyc.ce_idle;
                    cyc.done <= 1'b1;
                    st <= C_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc.rdata <= '0;
        end else if (st == C_STROBE && cnt == 8'h00 && !is_wr) begin
            cyc.rdata <= dq_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_we_data_stable: assert property (
        $rose(we_n) |-> $stable(dq_out) && $stable(flash_addr) && !dq_oe_n)
        else $error("Write data or address moved at strobe release");
    a_we_pulse_width: assert property (
        $fell(we_n) |-> (!we_n && !dq_oe_n) [*2] ##1 we_n)
        else $error("Write strobe width wrong");
    a_ce_idle_track: assert property (
        (st == C_IDLE && $past(st) == C_IDLE && !$past(cyc.req))
        |-> chip_select_lines == $past(cyc.ce_idle))
        else $error("Chip select not idle pattern while idle");
endmodule : nfc_cycle
`default_nettype wire

/* src/nfc_host.sv */
/* Host controller for a parallel NOR flash: APB register slave, operation
   sequencer, reset and recovery timing, status line capture.
   Assumes pins synchronous to pclk and a board pull-up on the status line. */
// The APB slave port and the placing of the registers are this design's own decisions.
`default_nettype none
// What this block does
// - Three chip-enable lines select or deselect the device.
// - Width select low: 8-bit, lowest address bit picks the byte.
// - Width select high: 16-bit, second address bit is the lowest.
// - After reset release wait output-valid and wake times before reads, writes.
// - Address and data latched on write strobe rising edge; keep them stable.
// - Status line is open drain and needs a pull-up.
module nfc_host
    import nfc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [2:0] chip_select_lines,
    output logic oe_n,
    output logic we_n,
    output logic reset_powerdown_n,
    output logic wide_mode,
    input wire logic wsm_status_output
);
    typedef enum logic [2:0] {
        T_RESET_LOW, T_RECOVER, T_IDLE, T_CYCLE, T_SETTLE, T_BUSY
    } nfc_top_e;
    nfc_top_e st;
    logic [1:0] op;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [2:0] ce_act;
    logic [2:0] ce_idle;
    logic sts_q;
    logic sts_rise;
    logic err_flag;
    logic done_flag;
    logic access;
    logic wr_ctrl;
    logic wr_status;
    logic refused;
    logic launch;
    logic finish;
    logic t_out_exp;
    logic t_wake_exp;
    logic t_out_load;
    logic t_wake_load;
    logic [7:0] t_out_val;
    logic [7:0] t_wake_val;
    logic [ADDR_W-1:0] cur_pin_addr;
    logic [31:0] rd_word;

    nfc_cyc_if cyc();

    ////////////////////////////////////////////////////////////////////////////
    // Pin address from the unit address; word mode drops the byte lane
    function automatic logic [ADDR_W-1:0] map_addr(input logic [ADDR_W-1:0] a,
                                                   input logic wide);
        map_addr = wide ? {a[ADDR_W-2:0], 1'b0} : a;
    endfunction : map_addr

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_ADDR) ||
                    (a == REG_WDATA) || (a == REG_RDATA) || (a == REG_CFG);
    endfunction : is_mapped

    // Registers that may only change while no operation runs
    function automatic logic is_guarded(input logic [7:0] a);
        is_guarded = (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_WDATA) ||
                     (a == REG_CFG);
    endfunction : is_guarded

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign access = psel && penable && pready;
    assign wr_ctrl = access && pwrite && paddr == REG_CTRL;
    assign wr_status = access && pwrite && paddr == REG_STATUS;
    assign refused = access && pwrite && is_guarded(paddr) && st != T_IDLE;
    assign launch = wr_ctrl && st == T_IDLE;
    assign cur_pin_addr = map_addr(addr_reg, wide_mode);

    always_comb begin
        unique case (paddr)
            REG_CTRL: rd_word = 32'(op);
            REG_STATUS: rd_word = {16'h0000, cur_pin_addr[BLOCK_LSB +: BLOCK_W],
                2'b00, (st == T_RESET_LOW || st == T_RECOVER), done_flag, err_flag,
                sts_rise, sts_q, (st != T_IDLE)};
            REG_ADDR: rd_word = 32'(addr_reg);
            REG_WDATA: rd_word = 32'(wdata_reg);
            REG_RDATA: rd_word = 32'(rdata_reg);
            REG_CFG: rd_word = 32'({ce_idle, ce_act, wide_mode});
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                pslverr <= !is_mapped(paddr);
                prdata <= pwrite ? 32'h0000_0000 : rd_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers; ignored while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg <= '0;
            wdata_reg <= '0;
            wide_mode <= CFG_WIDE_RST;
            ce_act <= CE_ACT_RST;
            ce_idle <= CE_IDLE_RST;
            op <= OP_READ;
        end else if (access && pwrite && st == T_IDLE) begin
            unique case (paddr)
                REG_ADDR: addr_reg <= pwdata[ADDR_W-1:0];
                REG_WDATA: wdata_reg <= pwdata[DATA_W-1:0];
                REG_CTRL: op <= pwdata[1:0];
                REG_CFG: begin
                    wide_mode <= pwdata[CFG_WIDE_BIT];
                    ce_act <= pwdata[CFG_CE_ACT_LSB +: 3];
                    ce_idle <= pwdata[CFG_CE_IDLE_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status line: open drain, pulled up on the board, never driven here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= 1'b1;
        end else begin
            sts_q <= wsm_status_output;
        end
    end

    // Sticky flags; a set in the clearing cycle wins
    assign finish = (st == T_CYCLE && cyc.done && op != OP_WRITE_WAIT) ||
                    (st == T_BUSY && wsm_status_output) ||
                    (st == T_RECOVER && t_out_exp && t_wake_exp);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_rise <= 1'b0;
            err_flag <= 1'b0;
            done_flag <= 1'b0;
        end else begin
            sts_rise <= (sts_rise && !(wr_status && pwdata[ST_RISE])) ||
                        (wsm_status_output && !sts_q);
            err_flag <= (err_flag && !(wr_status && pwdata[ST_ERR])) || refused;
            done_flag <= (done_flag && !(wr_status && pwdata[ST_DONE])) || finish;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= '0;
        end else if (st == T_CYCLE && cyc.done && op == OP_READ) begin
            rdata_reg <= cyc.rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer; power-up starts with the flash held in reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= T_RESET_LOW;
            reset_powerdown_n <= 1'b0;
        end else begin
            unique case (st)
                T_RESET_LOW: begin
                    if (t_out_exp) begin
                        reset_powerdown_n <= 1'b1;
                        st <= T_RECOVER;
                    end
                end
                T_RECOVER: begin
                    // Both recovery times must pass before any cycle
                    if (t_out_exp && t_wake_exp) begin
                        st <= T_IDLE;
                    end
                end
                T_IDLE: begin
                    if (launch) begin
                        if (pwdata[1:0] == OP_RESET) begin
                            reset_powerdown_n <= 1'b0;
                            st <= T_RESET_LOW;
                        end else begin
                            st <= T_CYCLE;
                        end
                    end
                end
                T_CYCLE: begin
                    if (cyc.done) begin
                        st <= (op == OP_WRITE_WAIT) ? T_SETTLE : T_IDLE;
                    end
                end
                T_SETTLE: begin
                    // Gives the device time to pull the line low first
                    if (t_wake_exp) begin
                        st <= T_BUSY;
                    end
                end
                T_BUSY: begin
                    if (wsm_status_output) begin
                        st <= T_IDLE;
                    end
                end
                default: st <= T_RESET_LOW;
            endcase
        end
    end

    // Request to the cycle engine, one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc.req <= 1'b0;
            cyc.wr <= 1'b0;
            cyc.addr <= '0;
            cyc.wdata <= '0;
        end else begin
            cyc.req <= launch && pwdata[1:0] != OP_RESET;
            if (launch) begin
                cyc.wr <= pwdata[1:0] != OP_READ;
                cyc.addr <= map_addr(addr_reg, wide_mode);
                cyc.wdata <= wdata_reg;
            end
        end
    end

    assign cyc.ce_act = ce_act;
    assign cyc.ce_idle = ce_idle;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        t_out_load = (st == T_RESET_LOW && t_out_exp) ||
                     (launch && pwdata[1:0] == OP_RESET);
        t_out_val = (st == T_RESET_LOW) ? OVALID_CYC : RP_LOW_LOAD;
        t_wake_load = (st == T_RESET_LOW && t_out_exp) ||
                      (st == T_CYCLE && cyc.done && op == OP_WRITE_WAIT);
        t_wake_val = (st == T_RESET_LOW) ? WAKE_CYC : SETTLE_CYC;
    end

    nfc_timer #(.INIT(RP_LOW_LOAD)) u_out_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(t_out_load),
        .load_val(t_out_val),
        .expired(t_out_exp)
    );

    nfc_timer #(.INIT(8'h00)) u_wake_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(t_wake_load),
        .load_val(t_wake_val),
        .expired(t_wake_exp)
    );

    nfc_cycle u_cycle (
        .pclk(pclk),
        .presetn(presetn),
        .cyc(cyc.eng),
        .flash_addr(flash_addr),
        .dq_out(dq_out),
        .dq_oe_n(dq_oe_n),
        .dq_in(dq_in),
        .chip_select_lines(chip_select_lines),
        .oe_n(oe_n),
        .we_n(we_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_write_after_wake: assert property (
        !we_n |-> reset_powerdown_n && t_wake_exp && st == T_CYCLE)
        else $error("Write strobe before wake time");
    a_read_after_valid: assert property (
        !oe_n |-> reset_powerdown_n && t_out_exp)
        else $error("Output enable before output-valid time");
    a_word_addr_lsb: assert property (
        (!oe_n || !we_n) && wide_mode |-> flash_addr == {addr_reg[ADDR_W-2:0], 1'b0})
        else $error("Word mode address not shifted");
    a_byte_addr_pass: assert property (
        (!oe_n || !we_n) && !wide_mode |-> flash_addr == addr_reg)
        else $error("Byte mode address altered");
    a_reset_low_width: assert property (
        $fell(reset_powerdown_n) |-> (!reset_powerdown_n) [*4] ##1 reset_powerdown_n)
        else $error("Reset pulse width wrong");
    a_busy_done: assert property (
        st == T_BUSY && wsm_status_output |=> st == T_IDLE && done_flag)
        else $error("Busy wait did not complete");

    c_write_wait: cover property (st == T_BUSY ##1 st == T_IDLE);
    c_read_cycle: cover property ($rose(oe_n) ##[1:4] st == T_IDLE);
    c_reset_op: cover property ($fell(reset_powerdown_n) ##[1:60] st == T_IDLE);
    c_refused: cover property ($rose(err_flag));
endmodule : nfc_host
`default_nettype wire

/* verif/nfc_flash_model.sv */
/* Behavioural flash device facing the host controller pins.
   Assumes pins synchronous to pclk; the bench adds the status pull-up. */
`default_nettype none
module nfc_flash_model
    import nfc_pkg::*;
#(
    parameter logic [15:0] ID_CODE = 16'hC3A5, // Arbitrary value
    parameter int BUSY_CYC = 40
)
(
    input wire logic pclk,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe_n,
    output logic [DATA_W-1:0] dq_in,
    input wire logic [2:0] chip_select_lines,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_powerdown_n,
    input wire logic wide_mode,
    output logic sts_oe_n
);
    logic id_mode, armed, we_q, lk_armed;
    logic [255:0] lock;
    logic [15:0] rd, last;
    int busy;
    wire [23:0] wa = flash_addr[24:1];
    wire sel = chip_select_lines == 3'h0 && reset_powerdown_n;
    assign rd = (id_mode && wa == 24'h00_0001) ? ID_CODE : {wa[7:0], ~wa[7:0]};
    // Released bus shows inverted history, never a stale match
    assign dq_in = (sel && !oe_n) ? (wide_mode ? rd :
        {8'h00, flash_addr[0] ? rd[15:8] : rd[7:0]}) : ~last;
    assign sts_oe_n = busy == 0;
    always_ff @(posedge pclk) last <= dq_in;
    always_ff @(posedge pclk or negedge reset_powerdown_n) begin
        if (!reset_powerdown_n) begin
            id_mode <= 1'b0;
            armed <= 1'b0;
            lk_armed <= 1'b0;
            // Locks cleared by reset; simpler than a nonvolatile copy
            lock <= '0;
            busy <= 0;
            we_q <= 1'b1;
        end else begin
            we_q <= we_n;
            if (busy != 0) busy <= busy - 1;
            if (sel && !we_q && we_n && !dq_oe_n && busy == 0) begin
                armed <= dq_out[7:0] == 8'h20;
                // Arbitrary lock codes: setup 6A, set 5E, clear all C1
                lk_armed <= dq_out[7:0] == 8'h6A;
                if (lk_armed && dq_out[7:0] == 8'h5E) lock[flash_addr[24:17]] <= 1'b1;
                if (lk_armed && dq_out[7:0] == 8'hC1) lock <= '0;
                if (dq_out[7:0] == 8'h90) id_mode <= 1'b1;
                if (dq_out[7:0] == 8'hFF) id_mode <= 1'b0;
                // Erase refused on a locked block
                if (armed && dq_out[7:0] == 8'hD0 && !lock[flash_addr[24:17]])
                    busy <= BUSY_CYC;
            end
        end
    end
endmodule : nfc_flash_model
`default_nettype wire

/* verif/nfc_host_test.sv */
/* Self-checking bench of the flash host controller over APB.
   Assumes the flash model file and the design sources are compiled first. */
`default_nettype none
module nfc_host_test;
    import nfc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] ID = 16'hC3A5; // Arbitrary value
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [ADDR_W-1:0] flash_addr;
    logic [DATA_W-1:0] dq_out, dq_in;
    logic dq_oe_n, oe_n, we_n, reset_powerdown_n, wide_mode, sts_oe_n;
    logic [2:0] chip_select_lines;
    int fail_count, checked, n;
    wire wsm_status_output = sts_oe_n ? 1'b1 : 1'b0; // Pull-up
    nfc_host nfc_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .flash_addr, .dq_out, .dq_oe_n, .dq_in,
        .chip_select_lines, .oe_n, .we_n, .reset_powerdown_n, .wide_mode, .wsm_status_output);
    nfc_flash_model #(.ID_CODE(ID)) nfc_flash_model_i (.pclk, .flash_addr, .dq_out,
        .dq_oe_n, .dq_in, .chip_select_lines, .oe_n, .we_n, .reset_powerdown_n,
        .wide_mode, .sts_oe_n);
    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Polls done, then clears the sticky flags; n counts polls
    task op(input logic [31:0] a, input logic [15:0] d, input logic [1:0] c);
        apb(1'b1, REG_ADDR, a);
        apb(1'b1, REG_WDATA, {16'h0000, d});
        apb(1'b1, REG_CTRL, {30'h0, c});
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (r[ST_DONE] !== 1'b1 && n < 400);
        chk(32'(r[ST_DONE]), 32'h1);
        apb(1'b1, REG_STATUS, 32'h0000_001C);
    endtask : op
    task final_report;
        $display("checks %0d failures %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////
    task t_start;
        apb(1'b1, REG_ADDR, 32'h5); // Refused while the flash is held in reset
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (r[0] !== 1'b0 && n < 200);
        chk(32'(r[0]), 32'h0);
        chk(32'(r[ST_ERR]), 32'h1);
        chk(32'(reset_powerdown_n), 32'h1);
        chk(32'(chip_select_lines), 32'h7);
        apb(1'b0, REG_CFG, 32'h0);
        chk(r, 32'h0000_0071);
        chk(32'(wide_mode), 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(e), 32'h1);
        apb(1'b1, REG_STATUS, 32'h0000_001C);
    endtask : t_start
    task t_ident;
        op(32'h0, 16'h0090, OP_WRITE);
        op(32'h1, 16'h0000, OP_READ);
        apb(1'b0, REG_RDATA, 32'h0);
        chk(r, {16'h0000, ID});
    endtask : t_ident
    task t_width;
        apb(1'b1, REG_CFG, 32'h0000_0070);
        @(posedge pclk); // Register lands at the access edge
        chk(32'(wide_mode), 32'h0);
        op(32'h0, 16'h00FF, OP_WRITE);
        op(32'h5, 16'h0000, OP_READ);
        apb(1'b0, REG_RDATA, 32'h0);
        chk(r, 32'h0000_0002);
        op(32'h4, 16'h0000, OP_READ);
        apb(1'b0, REG_RDATA, 32'h0);
        chk(r, 32'h0000_00FD);
        apb(1'b1, REG_CFG, 32'h0000_0071);
        op(32'h2, 16'h0000, OP_READ);
        apb(1'b0, REG_RDATA, 32'h0);
        chk(r, 32'h0000_02FD);
    endtask : t_width
    task t_erase;
        op(32'h0012_0000, 16'h0020, OP_WRITE);
        op(32'h0012_0000, 16'h00D0, OP_WRITE_WAIT);
        chk(32'(n >= 12), 32'h1);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(32'(r[15:8]), 32'h12);
        chk(32'(r[1]), 32'h1);
    endtask : t_erase
    // Locked block: erase refused, no busy wait; cleared: erase runs
    task t_lock;
        op(32'h0012_0000, 16'h006A, OP_WRITE);
        op(32'h0012_0000, 16'h005E, OP_WRITE);
        op(32'h0012_0000, 16'h0020, OP_WRITE);
        op(32'h0012_0000, 16'h00D0, OP_WRITE_WAIT);
        chk(32'(n < 12), 32'h1);
        op(32'h0, 16'h006A, OP_WRITE);
        op(32'h0, 16'h00C1, OP_WRITE);
        op(32'h0012_0000, 16'h0020, OP_WRITE);
        op(32'h0012_0000, 16'h00D0, OP_WRITE_WAIT);
        chk(32'(n >= 12), 32'h1);
    endtask : t_lock
    task t_rstop;
        op(32'h0, 16'h0090, OP_WRITE);
        op(32'h0, 16'h0000, OP_RESET);
        op(32'h1, 16'h0000, OP_READ);
        apb(1'b0, REG_RDATA, 32'h0);
        chk(r, 32'h0000_01FE);
    endtask : t_rstop
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        #2000000;
        fail_count++;
        final_report();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge pclk);
        chk(32'(reset_powerdown_n), 32'h0);
        presetn <= 1'b1;
        t_start();
        t_ident();
        t_width();
        t_erase();
        t_lock();
        t_rstop();
        final_report();
    end
endmodule : nfc_host_test
`default_nettype wire
